// file: inc/pbc_pkg.sv
// Behaviour
// RULE1 - isolate bit detaches the mac-side port; management access keeps working
// RULE2 - writing one to restart bit begins auto-negotiation again
// RULE3 - restart write is ignored while auto-negotiation enable is zero
// RULE4 - restart bit reads one until negotiation starts, then clears itself
// RULE5 - writing zero to restart bit never disturbs a running negotiation
// RULE6 - manual duplex bit: one full, zero half; reset value from strap
// RULE7 - with collision test, col follows tx_en within 512 bit times
// RULE8 - with collision test, col drops within four bit times of tx_en
// RULE9 - speed msb resets to one and joins speed lsb as field
// RULE10 - control bits five to zero ignore writes and read zero
// RULE11 - status reports tx and te capabilities as one, t4 and t2 zero
// RULE12 - status extended status bit always reads one
// RULE13 - frames accepted without preamble after one 32-bit preamble; bit reads one
// RULE14 - negotiation complete bit shows finished process, resets to zero
// RULE15 - remote fault latches high, clears on status read or reset
// RULE16 - auto-negotiation ability bit always reads one
// RULE17 - link failure clears link bit and it stays zero
// RULE18 - link bit returns to one only with valid link and status read
// RULE19 - jabber in 10 mb/s latches high until status read or reset
// RULE20 - extended capability bit always reads one
// RULE21 - status bit seven reserved, reads zero, host writes zero
// RULE22 - enable set ignores manual speed and duplex, clear uses them
// RULE23 - speed field 00 is 10, 01 is 100, 10 is 1000, 11 reserved
// RULE24 - status read returns latched values first, then clears the latches
package pbc_pkg;
  // register addresses on the management bus
  localparam logic [4:0]  REG_CTRL      = 5'h00;
  localparam logic [4:0]  REG_STAT      = 5'h01;
  // control register fields
  localparam int          B_SPD_LSB     = 13;
  localparam int          B_AN_EN       = 12;
  localparam int          B_ISO         = 10;
  localparam int          B_RESTART     = 9;
  localparam int          B_DUPLEX      = 8;
  localparam int          B_COLT        = 7;
  localparam int          B_SPD_MSB     = 6;
  localparam int          CTRL_RSVD_HI  = 5;
  // status register fields
  localparam int          B_AN_DONE     = 5;
  localparam int          B_RFAULT      = 4;
  localparam int          B_LINK        = 2;
  localparam int          B_JAB         = 1;
  localparam int          B_STAT_RSVD   = 7;
  // fixed capabilities: 14..11, 8, 6, 3, 0 set
  localparam logic [15:0] STAT_CAPS     = 16'h7949;
  // speed codes
  localparam logic [1:0]  SPD_10        = 2'h0;
  localparam logic [1:0]  SPD_100       = 2'h1;
  localparam logic [1:0]  SPD_1000      = 2'h2;
  localparam logic [1:0]  SPD_RSVD      = 2'h3;
  localparam logic [1:0]  CTRL_SPD_RST  = SPD_1000;
  // management frame layout
  localparam logic [1:0]  OP_WR         = 2'h1;
  localparam logic [1:0]  OP_RD         = 2'h2;
  localparam int          PRE_BITS      = 32;
  localparam int          HDR_BITS      = 12;
  localparam int          DATA_BITS     = 16;
  // collision test release bound: 4 bit times at 100 mb/s
  localparam int          CLK_NS        = 4;
  localparam int          COL_OFF_NS    = 40;
  localparam int          COL_OFF_CYC   = COL_OFF_NS / CLK_NS;

  // resolved link settings toward the datapath
  typedef struct packed {
    logic [1:0] speed;
    logic       full_duplex;
    logic       isolate;
  } pbc_link_cfg_type;

  // one management write
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] data;
  } pbc_mgmt_wr_type;
endpackage : pbc_pkg

// file: hdl/pbc_mdio_slave.sv
`timescale 1ns/100ps
module pbc_mdio_slave import pbc_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter int         PRE_LEN  = PRE_BITS
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // management pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // register side
  output logic             rd_req,
  output logic [4:0]       rd_addr,
  input  wire logic [15:0] rd_data,
  output logic             wr_stb,
  output pbc_mgmt_wr_type  wr
);
  generate
    if (PRE_LEN < 1 || PRE_LEN > PRE_BITS) begin : g_chk
      $error("PRE_LEN out of range");
    end
  endgenerate

  typedef enum logic [5:0] {
    M_PRE  = 6'h01,
    M_IDLE = 6'h02,
    M_ST   = 6'h04,
    M_HDR  = 6'h08,
    M_TA   = 6'h10,
    M_DAT  = 6'h20
  } pbc_mstate_type;

  pbc_mstate_type st;
  logic [2:0]     mdc_s;
  logic [1:0]     dio_s;
  logic [4:0]     cnt;
  logic [11:0]    hdr;
  logic [15:0]    sh;
  logic           is_rd;
  logic           hit;
  logic           rise;
  logic           bit_in;
  logic [11:0]    nh;

  // pins are asynchronous to ref_clk, two flops before use
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mdc_s <= 3'h0;
      dio_s <= 2'h0;
    end else begin
      mdc_s <= {mdc_s[1:0], mdc};
      dio_s <= {dio_s[0], mdio_in};
    end
  end

  assign rise   = mdc_s[1] & ~mdc_s[2];
  assign bit_in = dio_s[1];
  assign nh     = {hdr[10:0], bit_in};

  // frame engine, advanced on each mdc rising edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st       <= M_PRE;
      cnt      <= 5'h00;
      hdr      <= 12'h000;
      sh       <= 16'h0000;
      is_rd    <= 1'b0;
      hit      <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      rd_addr  <= 5'h00;
      rd_req   <= 1'b0;
      wr_stb   <= 1'b0;
      wr       <= '0;
    end else begin
      rd_req <= 1'b0;
      wr_stb <= 1'b0;
      if (rise) begin
        case (st)
          // full preamble only needed after reset or a bad frame
          M_PRE: begin
            if (!bit_in) begin
              cnt <= 5'h00;
            end else if (cnt == 5'(PRE_LEN - 1)) begin // [RULE13]
              st  <= M_IDLE;
              cnt <= 5'h00;
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
          // preamble may be skipped from here on
          M_IDLE: if (!bit_in) st <= M_ST; // [RULE13]
          M_ST: begin
            cnt <= 5'h00;
            st  <= bit_in ? M_HDR : M_IDLE;
          end
          M_HDR: begin
            hdr <= nh;
            cnt <= cnt + 5'h01;
            if (cnt == 5'(HDR_BITS - 1)) begin
              cnt     <= 5'h00;
              rd_addr <= nh[4:0];
              is_rd   <= (nh[11:10] == OP_RD);
              hit     <= (nh[9:5] == PHY_ADDR);
              // unknown opcode: demand a preamble again
              if (nh[11:10] != OP_RD && nh[11:10] != OP_WR)
                st <= M_PRE; // [RULE13]
              else
                st <= M_TA;
            end
          end
          M_TA: begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h00) begin
              if (is_rd) begin
                mdio_oe  <= hit;
                mdio_out <= 1'b0;
                sh       <= rd_data;
                rd_req   <= hit; // [RULE24]
              end else if (!bit_in) begin
                st  <= M_PRE; // [RULE13]
                cnt <= 5'h00;
              end
            end else begin
              cnt <= 5'h00;
              if (is_rd) begin
                mdio_out <= sh[15];
                sh       <= {sh[14:0], 1'b0};
                st       <= M_DAT;
              end else begin
                st <= bit_in ? M_PRE : M_DAT; // [RULE13]
              end
            end
          end
          M_DAT: begin
            cnt <= cnt + 5'h01;
            if (is_rd) begin
              mdio_out <= sh[15];
              sh       <= {sh[14:0], 1'b0};
            end else begin
              sh <= {sh[14:0], bit_in};
            end
            if (cnt == 5'(DATA_BITS - 1)) begin
              st      <= M_IDLE;
              cnt     <= 5'h00;
              mdio_oe <= 1'b0;
              if (!is_rd && hit) begin
                wr_stb <= 1'b1;
                wr     <= {rd_addr, sh[14:0], bit_in};
              end
            end
          end
          default: st <= M_PRE;
        endcase
      end
    end
  end

  // the pin is only driven for an addressed read
  drive_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mdio_oe |-> is_rd && hit && (st == M_TA || st == M_DAT)) // [RULE13]
    else $error("mdio driven outside an addressed read");
endmodule : pbc_mdio_slave

// file: hdl/pbc_phy_regs.sv
`timescale 1ns/100ps
module pbc_phy_regs import pbc_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // management pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // configuration straps
  input  wire logic        strap_an_en,
  input  wire logic        strap_duplex,
  // mac side
  input  wire logic        tx_en,
  output logic             col,
  // auto-negotiation engine
  output logic             an_enable,
  output logic             an_restart,
  input  wire logic        an_started,
  input  wire logic        an_complete,
  input  wire logic [1:0]  an_speed,
  input  wire logic        an_full_duplex,
  // link datapath
  input  wire logic        link_ok,
  input  wire logic        rfault_evt,
  input  wire logic        jabber_evt,
  output pbc_link_cfg_type link_cfg
);
  logic            rd_req;
  logic [4:0]      rd_addr;
  logic [15:0]     rdata;
  logic            wr_stb;
  pbc_mgmt_wr_type wr;
  logic [2:0]      pin_a;
  logic [2:0]      pin_b;
  logic            strap_ld;
  logic [1:0]      spd;
  logic            an_en;
  logic            iso;
  logic            dup;
  logic            colt;
  logic            rst_pend;
  logic            an_done;
  logic            rf;
  logic            link_ll;
  logic            jab;
  logic            ctrl_wr;
  logic            st_rd;
  logic            restart_set;

  // speed decode shared by jabber gating and the checks
  function automatic logic spd_is_10(input logic [1:0] s);
    spd_is_10 = (s == SPD_10);
  endfunction : spd_is_10

  // serial management frames
  pbc_mdio_slave #(
    .PHY_ADDR (PHY_ADDR),
    .PRE_LEN  (PRE_BITS)
  ) u_mdio (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe),
    .rd_req   (rd_req),
    .rd_addr  (rd_addr),
    .rd_data  (rdata),
    .wr_stb   (wr_stb),
    .wr       (wr)
  );

  assign ctrl_wr = wr_stb && (wr.addr == REG_CTRL);
  assign st_rd   = rd_req && (rd_addr == REG_STAT);
  // a restart request needs the enable in the same write
  assign restart_set = ctrl_wr && wr.data[B_RESTART]
                       && wr.data[B_AN_EN]; // [RULE3]

  // pin inputs; no reset so straps are valid at release
  always_ff @(posedge ref_clk) begin
    pin_a <= {tx_en, strap_duplex, strap_an_en};
    pin_b <= pin_a;
  end

  // strap load happens one cycle after reset release
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      strap_ld <= 1'b1;
    else
      strap_ld <= 1'b0;
  end

  // control register storage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      spd   <= CTRL_SPD_RST; // [RULE9]
      an_en <= 1'b0;
      dup   <= 1'b0;
      iso   <= 1'b0;
      colt  <= 1'b0;
    end else if (ctrl_wr) begin
      // bits 5..0 are simply never stored
      spd   <= {wr.data[B_SPD_MSB], wr.data[B_SPD_LSB]}; // [RULE9] [RULE10]
      an_en <= wr.data[B_AN_EN];
      iso   <= wr.data[B_ISO];
      dup   <= wr.data[B_DUPLEX];
      colt  <= wr.data[B_COLT];
    end else if (strap_ld) begin
      an_en <= pin_b[0];
      dup   <= pin_b[1]; // [RULE6]
    end
  end

  // restart request: only hardware clears it, writes of zero do nothing
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      rst_pend <= 1'b0;
    else if (restart_set)
      rst_pend <= 1'b1; // [RULE2]
    else if (an_started)
      rst_pend <= 1'b0; // [RULE4] [RULE5]
  end

  assign an_enable  = an_en;
  assign an_restart = rst_pend; // [RULE2]

  // resolved speed and duplex; reserved code keeps last speed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link_cfg <= '0;
    end else begin
      link_cfg.isolate <= iso; // [RULE1]
      if (an_en) begin
        link_cfg.speed       <= an_speed; // [RULE22]
        link_cfg.full_duplex <= an_full_duplex;
      end else begin
        if (spd != SPD_RSVD)
          link_cfg.speed <= spd; // [RULE23]
        link_cfg.full_duplex <= dup; // [RULE6] [RULE22]
      end
    end
  end

  // collision test loops tx_en to col; isolation forces it low
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      col <= 1'b0;
    else
      col <= colt && pin_b[2] && !iso; // [RULE7] [RULE8] [RULE1]
  end

  // negotiation progress mirrors the engine
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      an_done <= 1'b0;
    else
      an_done <= an_complete; // [RULE14]
  end

  // latched-high remote fault; a new event beats the read clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      rf <= 1'b0;
    else if (rfault_evt)
      rf <= 1'b1; // [RULE15]
    else if (st_rd)
      rf <= 1'b0; // [RULE24]
  end

  // latched-high jabber, only meaningful at 10 mb/s
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      jab <= 1'b0;
    else if (jabber_evt && spd_is_10(link_cfg.speed))
      jab <= 1'b1; // [RULE19]
    else if (st_rd)
      jab <= 1'b0; // [RULE24]
  end

  // latched-low link: drops at once, rises only on a status read
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      link_ll <= 1'b0;
    else if (!link_ok)
      link_ll <= 1'b0; // [RULE17]
    else if (st_rd)
      link_ll <= 1'b1; // [RULE18] [RULE24]
  end

  // read data; sampled by the frame engine before latches clear
  always_comb begin
    rdata = 16'h0000;
    case (rd_addr)
      REG_CTRL: begin
        rdata[B_SPD_LSB] = spd[0];
        rdata[B_AN_EN]   = an_en;
        rdata[B_ISO]     = iso;
        rdata[B_RESTART] = rst_pend; // [RULE4]
        rdata[B_DUPLEX]  = dup;
        rdata[B_COLT]    = colt;
        rdata[B_SPD_MSB] = spd[1];
      end
      REG_STAT: begin
        rdata            = STAT_CAPS; // [RULE11] [RULE12] [RULE16] [RULE20]
        rdata[B_AN_DONE] = an_done;
        rdata[B_RFAULT]  = rf;
        rdata[B_LINK]    = link_ll;
        rdata[B_JAB]     = jab; // [RULE13] [RULE21]
      end
      default: rdata = 16'h0000;
    endcase
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence restart_wr_s;
    restart_set;
  endsequence

  sequence restart_taken_s;
    rst_pend && an_started && !restart_set;
  endsequence

  sequence tx_idle_s;
    !tx_en [*3];
  endsequence

  restart_set_a: assert property (restart_wr_s |=> rst_pend) // [RULE2]
    else $error("restart write not held");

  restart_ign_a: assert property ( // [RULE3]
    ctrl_wr && !wr.data[B_AN_EN] && !rst_pend && !an_restart |=> !rst_pend)
    else $error("restart taken while negotiation disabled");

  restart_clr_a: assert property (restart_taken_s |=> !rst_pend) // [RULE4]
    else $error("restart bit did not self clear");

  restart_keep_a: assert property ( // [RULE5]
    rst_pend && ctrl_wr && !an_started |=> rst_pend)
    else $error("write cleared a pending restart");

  col_on_a: assert property ( // [RULE7]
    colt && !iso && pin_b[2] |=> col)
    else $error("collision test did not raise col");

  col_off_a: assert property (tx_idle_s |=> !col) // [RULE8]
    else $error("col held after tx_en dropped");

  isolate_a: assert property (iso |=> !col && link_cfg.isolate) // [RULE1]
    else $error("isolated port still active");

  speed_rst_a: assert property ( // [RULE9]
    strap_ld |-> spd == CTRL_SPD_RST && link_cfg == '0)
    else $error("speed field reset wrong");

  ctrl_rsvd_a: assert property ( // [RULE10]
    rd_addr == REG_CTRL |-> rdata[CTRL_RSVD_HI:0] == '0)
    else $error("control reserved bits not zero");

  stat_caps_a: assert property ( // [RULE11]
    rd_addr == REG_STAT |->
      (rdata & ~16'h0036) == STAT_CAPS && !rdata[B_STAT_RSVD])
    else $error("status fixed bits wrong");

  rfault_hold_a: assert property ( // [RULE15]
    rf && !st_rd |=> rf ##0 $stable(rf) [*1])
    else $error("remote fault lost without read");

  rfault_clr_a: assert property ( // [RULE24]
    st_rd && rdata[B_RFAULT] && !rfault_evt |=> !rf)
    else $error("read did not clear remote fault");

  link_drop_a: assert property (!link_ok |=> !link_ll) // [RULE17]
    else $error("link bit stayed up on failure");

  link_hold_a: assert property (!link_ll && !st_rd |=> !link_ll) // [RULE18]
    else $error("link bit rose without a read");

  jab_a: assert property ( // [RULE19]
    jabber_evt && spd_is_10(link_cfg.speed) |=> jab [*2] or (jab ##1 !jab))
    else $error("jabber event not latched");

  // judge the read path, not just the internal copy
  function automatic logic rdata_done_ok(input logic [15:0] d);
    rdata_done_ok = d[B_AN_DONE];
  endfunction : rdata_done_ok

  an_done_a: assert property ( // [RULE14]
    an_complete |=> rd_addr != REG_STAT || rdata_done_ok(rdata))
    else $error("negotiation complete not reported");
endmodule : pbc_phy_regs

// file: verification/pbc_mgmt_host.sv
`timescale 1ns/100ps
// station manager model: mdc stands low between frames, mdio is pulled up
module pbc_mgmt_host import pbc_pkg::*; #(
  parameter int         HALF = 5,
  parameter logic [4:0] PHY  = 5'h00
) (
  // clock
  input  wire logic ref_clk,
  // management pins
  output logic      mdc,
  output logic      host_out,
  output logic      host_oe,
  input  wire logic mdio_lvl
);
  initial begin
    mdc      = 1'b0;
    host_out = 1'b1;
    host_oe  = 1'b0;
  end

  // one bit: drive while mdc is low, sample the wire just before the rise
  task automatic put_bit(input logic oe, input logic val, output logic smp);
    host_oe  <= oe;
    host_out <= val;
    mdc      <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    smp = mdio_lvl;
    mdc <= 1'b1;
    repeat (HALF) @(posedge ref_clk);
  endtask : put_bit

  // whole frame; reads release the wire from the first turnaround bit on
  task automatic xfer(input logic pre, input logic [1:0] op,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic        smp;
    logic [31:0] frm;
    frm = {2'b01, op, PHY, ra, 2'b10, wd};
    rd  = 16'h0000;
    // preamble only where the caller asks for it
    if (pre) begin
      for (int i = 0; i < PRE_BITS; i++) begin
        put_bit(1'b1, 1'b1, smp);
      end
    end
    // status is only ever read, so its reserved bit is never written
    for (int i = 31; i >= 0; i--) begin
      put_bit((op != OP_RD) || (i >= 18), frm[i], smp);
      rd = {rd[14:0], smp};
    end
    host_oe <= 1'b0;
    mdc     <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
endmodule : pbc_mgmt_host

// file: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top import pbc_pkg::*;;
  logic             ref_clk;
  logic             sys_rst;
  logic             mdc;
  logic             mdio_out;
  logic             mdio_oe;
  logic             host_out;
  logic             host_oe;
  logic             mdio_lvl;
  logic             strap_an_en;
  logic             strap_duplex;
  logic             tx_en;
  logic             col;
  logic             an_enable;
  logic             an_restart;
  logic             an_started;
  logic             an_complete;
  logic [1:0]       an_speed;
  logic             an_full_duplex;
  logic             link_ok;
  logic             rfault_evt;
  logic             jabber_evt;
  pbc_link_cfg_type link_cfg;
  logic [15:0]      rdat;
  int               fails;
  int               check_count;
  int               cyc = 0;

  // pull-up wins when neither side drives
  assign mdio_lvl = mdio_oe ? mdio_out : (host_oe ? host_out : 1'b1);

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  pbc_phy_regs u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_lvl),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .strap_an_en(strap_an_en),
    .strap_duplex(strap_duplex), .tx_en(tx_en), .col(col),
    .an_enable(an_enable), .an_restart(an_restart),
    .an_started(an_started), .an_complete(an_complete),
    .an_speed(an_speed), .an_full_duplex(an_full_duplex),
    .link_ok(link_ok), .rfault_evt(rfault_evt), .jabber_evt(jabber_evt),
    .link_cfg(link_cfg)
  );

  pbc_mgmt_host u_host (
    .ref_clk(ref_clk), .mdc(mdc), .host_out(host_out), .host_oe(host_oe),
    .mdio_lvl(mdio_lvl)
  );

  task automatic stop_test;
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [4:0] ra, input logic pre);
    u_host.xfer(pre, OP_RD, ra, 16'h0000, rdat);
  endtask : rd

  // control write, then let the register update land
  task automatic wr(input logic [15:0] d);
    logic [15:0] dummy;
    u_host.xfer(1'b0, OP_WR, REG_CTRL, d, dummy);
    repeat (4) @(posedge ref_clk);
  endtask : wr

  task automatic t_reset;
    rd(REG_CTRL, 1'b1);
    chk(rdat, 16'h1140);
    chk({15'h0, an_enable}, 16'h0001);
    chk({12'h0, link_cfg}, 16'h0004);
    rd(REG_STAT, 1'b0);
    chk(rdat, 16'h7949);
    rd(REG_STAT, 1'b0);
    chk(rdat, 16'h794d);
  endtask : t_reset

  task automatic t_manual;
    logic [15:0] d;
    for (int c = 0; c < 3; c++) begin
      d = {2'b00, c[0], 4'h0, c[0], 1'b0, c[1], 6'h3f};
      wr(d);
      rd(REG_CTRL, 1'b0);
      chk(rdat, d & 16'hffc0);
      chk({12'h0, link_cfg}, {12'h0, c[1:0], c[0], 1'b0});
    end
    // reserved code keeps the previous speed
    wr(16'h2040);
    chk({12'h0, link_cfg}, 16'h0008);
  endtask : t_manual

  task automatic t_colt;
    int n;
    wr(16'h2180);
    tx_en <= 1'b1;
    for (n = 0; n < 20 && col !== 1'b1; n++) @(posedge ref_clk);
    chk({15'h0, col}, 16'h0001);
    tx_en <= 1'b0;
    for (n = 0; n < COL_OFF_CYC && col !== 1'b0; n++) @(posedge ref_clk);
    chk({15'h0, col}, 16'h0000);
    wr(16'h2580);
    tx_en <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({15'h0, col}, 16'h0000);
    chk({12'h0, link_cfg}, 16'h0007);
    rd(REG_CTRL, 1'b0);
    chk(rdat, 16'h2580);
    tx_en <= 1'b0;
  endtask : t_colt

  task automatic t_restart;
    wr(16'h0200);
    chk({15'h0, an_restart}, 16'h0000);
    wr(16'h1200);
    chk({15'h0, an_restart}, 16'h0001);
    rd(REG_CTRL, 1'b0);
    chk(rdat, 16'h1200);
    wr(16'h1000);
    chk({15'h0, an_restart}, 16'h0001);
    an_started <= 1'b1;
    @(posedge ref_clk);
    an_started <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({15'h0, an_restart}, 16'h0000);
    rd(REG_CTRL, 1'b0);
    chk(rdat, 16'h1000);
  endtask : t_restart

  // jabber only counts at 10 mb/s, so force that speed first
  task automatic t_latches;
    wr(16'h0000);
    rfault_evt <= 1'b1;
    jabber_evt <= 1'b1;
    @(posedge ref_clk);
    rfault_evt <= 1'b0;
    jabber_evt <= 1'b0;
    rd(REG_STAT, 1'b0);
    chk(rdat, 16'h795f);
    rd(REG_STAT, 1'b0);
    chk(rdat, 16'h794d);
    link_ok <= 1'b0;
    repeat (3) @(posedge ref_clk);
    link_ok     <= 1'b1;
    an_complete <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(REG_STAT, 1'b0);
    chk(rdat, 16'h7969);
    rd(REG_STAT, 1'b0);
    chk(rdat, 16'h796d);
  endtask : t_latches

  // a bad opcode drops the engine back to waiting for a preamble
  task automatic t_badop;
    logic [15:0] dummy;
    u_host.xfer(1'b0, 2'b11, REG_STAT, 16'hffff, dummy);
    rd(REG_STAT, 1'b0);
    chk(rdat, 16'hffff);
    rd(REG_STAT, 1'b1);
    chk(rdat, 16'h796d);
  endtask : t_badop

  // hang guard, well above the roughly 9.1k cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      stop_test;
    end
  end

  initial begin
    fails          = 0;
    check_count    = 0;
    sys_rst        = 1'b1;
    strap_an_en    = 1'b1;
    strap_duplex   = 1'b1;
    tx_en          = 1'b0;
    an_started     = 1'b0;
    an_complete    = 1'b0;
    an_speed       = 2'h1;
    an_full_duplex = 1'b0;
    link_ok        = 1'b1;
    rfault_evt     = 1'b0;
    jabber_evt     = 1'b0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset;
    t_manual;
    t_colt;
    t_restart;
    t_latches;
    t_badop;
    stop_test;
  end
endmodule : tb_top
